// *** rtl/swr_pkg.sv ***
// Constants, register map and state codes for the standby, wake and reset controller.
// Assumes a single 250 MHz clock and an AXI4-Lite master with 32-bit data.
//
// What this block does
// - Sixteen key pins raise key wake interrupt.
// - Key mask bits enable pins; reset clears.
// - Write-only level select register, reset clears.
// - Sleep register write halts CPU clock, not oscillator or prescaler.
// - Prescaler tap ten keeps running in sleep.
// - Peripheral clock enable zero halts peripherals in sleep.
// - Stop halts oscillator and all clocks.
// - Stop exit waits stabilization, sets clock enable.
// - Interval timer wakes sleep only, never stop.
// - Reset pin low releases standby, initializes.
// - Enabled external rising edge releases standby.
// - Enabled wake; mask picks continue or vector.
// - Pending enabled interrupt refuses standby entry.
// - Sleep keeps prescaler; stop halts all clocks.
// - Power-on hold about two-to-nineteen cycles.
// - Power-on counts oscillator cycles up to POR_CYCLES.
// - Low voltage locks out stop release.
package swr_pkg;
   // Register byte offsets.
   localparam logic [7:0] SWR_OFF_MASK_LO   = 8'h00;
   localparam logic [7:0] SWR_OFF_MASK_HI   = 8'h04;
   localparam logic [7:0] SWR_OFF_LEVEL     = 8'h08;
   localparam logic [7:0] SWR_OFF_SLEEP     = 8'h0C;
   localparam logic [7:0] SWR_OFF_STOP      = 8'h10;
   localparam logic [7:0] SWR_OFF_CLK_CTRL  = 8'h14;
   localparam logic [7:0] SWR_OFF_IRQ_EN    = 8'h18;
   localparam logic [7:0] SWR_OFF_STATUS    = 8'h1C;
   // Clock control field positions.
   localparam int SWR_CK_PCK_EN    = 0;
   localparam int SWR_CK_TAP_TEN   = 1;
   localparam int SWR_CK_STAB_LSB  = 2;
   // Interrupt enable field positions.
   localparam int SWR_IE_KEY   = 0;
   localparam int SWR_IE_EXT1  = 1;
   localparam int SWR_IE_EXT2  = 2;
   localparam int SWR_IE_TMR   = 3;
   localparam int SWR_IE_GMASK = 4;
   // Reset values.
   localparam logic [7:0] SWR_RST_MASK  = 8'h00;
   localparam logic [7:0] SWR_RST_LEVEL = 8'h00;
   localparam logic [4:0] SWR_RST_CK    = 5'h01;
   localparam logic [4:0] SWR_RST_IE    = 5'h00;
   // Timing: power-on hold is two to the nineteenth oscillator cycles.
   localparam int SWR_POR_LOG2     = 19;
   localparam int SWR_TAP_BIT      = 10;
   localparam int SWR_STAB_BASE    = 8;
   // AXI responses.
   localparam logic [1:0] SWR_RESP_OKAY   = 2'b00;
   localparam logic [1:0] SWR_RESP_SLVERR = 2'b10;
   typedef enum logic [4:0] {
      SWR_POR   = 5'b00001,
      SWR_RUN   = 5'b00010,
      SWR_SLEEP = 5'b00100,
      SWR_STOP  = 5'b01000,
      SWR_STAB  = 5'b10000
   } swr_state_e;
endpackage : swr_pkg

// *** rtl/swr_top.sv ***
// Standby, wake and power-on reset controller with an AXI4-Lite register slave.
// Assumes synchronous pins and a CPU that obeys the run and clock gate outputs.
`timescale 1ns/10ps
module swr_top
   import swr_pkg::*;
#(
   parameter int POR_CYCLES = 1 << SWR_POR_LOG2
)
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  key_port_a,
   input  wire logic [7:0]  key_port_b,
   input  wire logic        ext_irq_one,
   input  wire logic        ext_irq_two,
   input  wire logic        interval_timer_flag,
   input  wire logic [3:0]  irq_pending,
   input  wire logic        low_voltage,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             cpu_clk_en,
   output logic             osc_en,
   output logic             periph_clk_en,
   output logic             prescaler_run,
   output logic             timer_run,
   output logic             sys_reset,
   output logic             key_scan_wake,
   output logic             wake_vector,
   output logic             ports_input_only
);

   // ------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------
   if (POR_CYCLES < 2 || POR_CYCLES > (1 << 24)) begin : g_chk
      $error("POR_CYCLES out of range");
   end

   // ------------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------------
   logic [7:0]  mask_lo_q, mask_lo_d, mask_hi_q, mask_hi_d, level_q, level_d;
   logic [4:0]  ck_q, ck_d, ie_q, ie_d;
   logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
   logic [7:0]  awa_q, awa_d;
   logic [31:0] wd_q, wd_d, rd_q, rd_d;
   logic [1:0]  br_q, br_d, rr_q, rr_d;
   swr_state_e  st_q, st_d;
   logic [24:0] cnt_q, cnt_d;
   logic        e1_q, e1_d, e2_q, e2_d, lv_q, lv_d, vec_q, vec_d;
   logic        sleep_wr, stop_wr, do_wr;
   logic [15:0] key_pins, key_hit, key_mask;
   logic        key_any, ext_rise, tmr_wake, pend_block;
   logic [24:0] stab_cycles;

   // Key wake: a masked pin at its selected level; level bit 0 means low. The
   // level register is one byte, so each bit serves one pin of both ports.
   assign key_pins = {key_port_b, key_port_a};
   assign key_mask = {mask_hi_q, mask_lo_q};
   always_comb
   begin
      for (int i = 0; i < 16; i++)
      begin
         key_hit[i] = key_mask[i] &
                      (key_pins[i] == level_q[i % 8]);
      end
   end
   assign key_any       = |key_hit;
   assign key_scan_wake = key_any & ie_q[SWR_IE_KEY];
   assign ext_rise      = (ext_irq_one & ~e1_q & ie_q[SWR_IE_EXT1]) |
                          (ext_irq_two & ~e2_q & ie_q[SWR_IE_EXT2]);
   // Timer wakes only when clocked from tap ten and enabled.
   assign tmr_wake      = interval_timer_flag & ie_q[SWR_IE_TMR] & ck_q[SWR_CK_TAP_TEN];
   // Entry refused while an enabled request is already pending.
   assign pend_block    = |(irq_pending & ie_q[3:0]);
   assign stab_cycles   = 25'(1) << (SWR_STAB_BASE + int'(ck_q[4:2]));

   // ------------------------------------------------------------------
   // AXI4-Lite write path: address and data accepted in either order.
   // ------------------------------------------------------------------
   assign s_axi_awready = ~aw_q & ~bv_q;
   assign s_axi_wready  = ~w_q & ~bv_q;
   assign s_axi_arready = ~rv_q;
   assign s_axi_bvalid  = bv_q;
   assign s_axi_bresp   = br_q;
   assign s_axi_rvalid  = rv_q;
   assign s_axi_rdata   = rd_q;
   assign s_axi_rresp   = rr_q;
   assign do_wr    = aw_q & w_q & ~bv_q;
   assign sleep_wr = do_wr & (awa_q == SWR_OFF_SLEEP) & s_axi_wstrb_ok();
   assign stop_wr  = do_wr & (awa_q == SWR_OFF_STOP);

   function automatic logic s_axi_wstrb_ok();
      return 1'b1;
   endfunction : s_axi_wstrb_ok

   always_comb
   begin
      aw_d = aw_q; w_d = w_q; awa_d = awa_q; wd_d = wd_q; bv_d = bv_q; br_d = br_q;
      mask_lo_d = mask_lo_q; mask_hi_d = mask_hi_q; level_d = level_q;
      ck_d = ck_q; ie_d = ie_q;
      if (s_axi_awvalid && s_axi_awready)
      begin
         aw_d  = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         w_d  = 1'b1;
         wd_d = s_axi_wdata;
      end
      if (bv_q && s_axi_bready)
         bv_d = 1'b0;
      if (do_wr)
      begin
         aw_d = 1'b0;
         w_d  = 1'b0;
         bv_d = 1'b1;
         br_d = SWR_RESP_OKAY;
         unique case (awa_q)
            SWR_OFF_MASK_LO:  mask_lo_d = wd_q[7:0];
            SWR_OFF_MASK_HI:  mask_hi_d = wd_q[7:0];
            SWR_OFF_LEVEL:    level_d   = wd_q[7:0];
            SWR_OFF_CLK_CTRL: ck_d      = wd_q[4:0];
            SWR_OFF_IRQ_EN:   ie_d      = wd_q[4:0];
            SWR_OFF_SLEEP, SWR_OFF_STOP: ;
            default:          br_d = SWR_RESP_SLVERR;
         endcase
      end
      // Leaving stop forces the peripheral clock back on.
      if (st_q == SWR_STAB && cnt_q + 25'd1 >= stab_cycles)
         ck_d[SWR_CK_PCK_EN] = 1'b1;
      // Power-on selects tap ten automatically.
      if (st_q == SWR_POR)
         ck_d[SWR_CK_TAP_TEN] = 1'b1;
   end

   // Read path; the level register is write-only and reads zero.
   always_comb
   begin
      rv_d = rv_q; rd_d = rd_q; rr_d = rr_q;
      if (rv_q && s_axi_rready)
         rv_d = 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
         rv_d = 1'b1;
         rr_d = SWR_RESP_OKAY;
         unique case (s_axi_araddr)
            SWR_OFF_MASK_LO:  rd_d = {24'h000000, mask_lo_q};
            SWR_OFF_MASK_HI:  rd_d = {24'h000000, mask_hi_q};
            SWR_OFF_LEVEL, SWR_OFF_SLEEP, SWR_OFF_STOP: rd_d = 32'h00000000;
            SWR_OFF_CLK_CTRL: rd_d = {27'h0000000, ck_q};
            SWR_OFF_IRQ_EN:   rd_d = {27'h0000000, ie_q};
            SWR_OFF_STATUS:   rd_d = {24'h000000, lv_q, vec_q, key_any, st_q};
            default:
            begin
               rd_d = 32'h00000000;
               rr_d = SWR_RESP_SLVERR;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Power state machine
   // ------------------------------------------------------------------
   // A reset of the block (pin low) leaves any standby and restarts the
   // power-on hold; this is the only exit from low-voltage lockout.
   always_comb
   begin
      st_d = st_q; cnt_d = cnt_q; vec_d = vec_q;
      lv_d = lv_q | low_voltage;
      e1_d = ext_irq_one; e2_d = ext_irq_two;
      unique case (st_q)
         SWR_POR:
         begin
            cnt_d = cnt_q + 25'd1;
            if (cnt_q == 25'(POR_CYCLES - 1))
            begin
               st_d  = SWR_RUN;
               cnt_d = '0;
            end
         end
         SWR_RUN:
         begin
            if (sleep_wr && !pend_block && !lv_q)
               st_d = SWR_SLEEP;
            else if ((stop_wr && !pend_block) || low_voltage)
               st_d = SWR_STOP;
         end
         SWR_SLEEP:
         begin
            if (key_scan_wake || ext_rise || tmr_wake)
            begin
               st_d  = SWR_RUN;
               vec_d = ie_q[SWR_IE_GMASK];
            end
         end
         SWR_STOP:
         begin
            if ((key_scan_wake || ext_rise) && !lv_q)
            begin
               st_d  = SWR_STAB;
               cnt_d = '0;
               vec_d = ie_q[SWR_IE_GMASK];
            end
         end
         SWR_STAB:
         begin
            cnt_d = cnt_q + 25'd1;
            if (cnt_q + 25'd1 >= stab_cycles)
            begin
               st_d  = SWR_RUN;
               cnt_d = '0;
            end
         end
         default: st_d = SWR_POR;
      endcase
      // Lockout beats any wake or stabilization once the power-on hold is over.
      if ((low_voltage || lv_q) && st_d != SWR_POR)
         st_d = SWR_STOP;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_q <= SWR_POR; cnt_q <= '0; vec_q <= 1'b0; lv_q <= 1'b0;
         e1_q <= 1'b0; e2_q <= 1'b0;
         mask_lo_q <= SWR_RST_MASK; mask_hi_q <= SWR_RST_MASK;
         level_q <= SWR_RST_LEVEL;
         ck_q <= SWR_RST_CK; ie_q <= SWR_RST_IE;
         aw_q <= 1'b0; w_q <= 1'b0; awa_q <= 8'h00; wd_q <= 32'h00000000;
         bv_q <= 1'b0; br_q <= 2'b00; rv_q <= 1'b0; rd_q <= 32'h00000000; rr_q <= 2'b00;
      end
      else
      begin
         st_q <= st_d; cnt_q <= cnt_d; vec_q <= vec_d; lv_q <= lv_d;
         e1_q <= e1_d; e2_q <= e2_d;
         mask_lo_q <= mask_lo_d; mask_hi_q <= mask_hi_d; level_q <= level_d;
         ck_q <= ck_d; ie_q <= ie_d;
         aw_q <= aw_d; w_q <= w_d; awa_q <= awa_d; wd_q <= wd_d;
         bv_q <= bv_d; br_q <= br_d; rv_q <= rv_d; rd_q <= rd_d; rr_q <= rr_d;
      end
   end

   // ------------------------------------------------------------------
   // Clock gate outputs
   // ------------------------------------------------------------------
   // Sleep keeps oscillator and prescaler; stop halts everything.
   assign cpu_clk_en       = (st_q == SWR_RUN);
   assign osc_en           = (st_q != SWR_STOP);
   assign prescaler_run    = (st_q != SWR_STOP);
   assign periph_clk_en    = (st_q == SWR_RUN) | (st_q == SWR_SLEEP & ck_q[SWR_CK_PCK_EN]);
   assign timer_run        = (st_q == SWR_RUN) |
                             (st_q == SWR_SLEEP & ck_q[SWR_CK_TAP_TEN]) | (st_q == SWR_POR);
   assign sys_reset        = (st_q == SWR_POR);
   assign wake_vector      = vec_q;
   assign ports_input_only = lv_q;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   property p_stop_clocks;
      @(posedge aclk) disable iff (!aresetn)
      (st_q == SWR_STOP) |-> (!osc_en && !cpu_clk_en && !prescaler_run);
   endproperty
   a_stop_clocks: assert property (p_stop_clocks) else $error("clock on in stop");

   property p_sleep_osc;
      @(posedge aclk) disable iff (!aresetn)
      (st_q == SWR_SLEEP) |-> (osc_en && prescaler_run && !cpu_clk_en);
   endproperty
   a_sleep_osc: assert property (p_sleep_osc) else $error("sleep clocks wrong");

   property p_refuse;
      @(posedge aclk) disable iff (!aresetn)
      (st_q == SWR_RUN && pend_block) |=> (st_q != SWR_SLEEP);
   endproperty
   a_refuse: assert property (p_refuse) else $error("entered standby with pending");

   property p_tmr_stop;
      @(posedge aclk) disable iff (!aresetn)
      (st_q == SWR_STOP && !key_scan_wake && !ext_rise) |=> (st_q == SWR_STOP);
   endproperty
   a_tmr_stop: assert property (p_tmr_stop) else $error("stop left without cause");

   property p_stab_pck;
      @(posedge aclk) disable iff (!aresetn)
      (st_q == SWR_STAB) ##1 (st_q == SWR_RUN) |-> ck_q[SWR_CK_PCK_EN];
   endproperty
   a_stab_pck: assert property (p_stab_pck) else $error("clock enable not set");

   property p_key_wake;
      @(posedge aclk) disable iff (!aresetn)
      (st_q == SWR_SLEEP && key_scan_wake) |=> (st_q == SWR_RUN && cpu_clk_en);
   endproperty
   a_key_wake: assert property (p_key_wake) else $error("key did not wake");

   property p_ext_wake;
      @(posedge aclk) disable iff (!aresetn)
      (st_q == SWR_STOP && ext_rise && !lv_q) |=> (st_q == SWR_STAB);
   endproperty
   a_ext_wake: assert property (p_ext_wake) else $error("edge did not release stop");

   property p_por_reset;
      @(posedge aclk) disable iff (!aresetn)
      $rose(st_q == SWR_RUN) |-> $past(sys_reset) || $past(st_q == SWR_STAB) ||
                                 $past(st_q == SWR_SLEEP);
   endproperty
   a_por_reset: assert property (p_por_reset) else $error("bad entry to run");

   property p_lockout;
      @(posedge aclk) disable iff (!aresetn)
      lv_q |=> (lv_q && ports_input_only && st_q != SWR_STAB);
   endproperty
   a_lockout: assert property (p_lockout) else $error("lockout left");

   property p_lockout_stop;
      @(posedge aclk) disable iff (!aresetn)
      (lv_q && st_q != SWR_POR) |-> (st_q == SWR_STOP);
   endproperty
   a_lockout_stop: assert property (p_lockout_stop) else $error("lockout not in stop");

   property p_sleep_tmr;
      @(posedge aclk) disable iff (!aresetn)
      (st_q == SWR_SLEEP) |-> (timer_run == ck_q[SWR_CK_TAP_TEN]);
   endproperty
   a_sleep_tmr: assert property (p_sleep_tmr) else $error("timer clock wrong in sleep");

   property p_sleep_pck;
      @(posedge aclk) disable iff (!aresetn)
      (st_q == SWR_SLEEP) |-> (periph_clk_en == ck_q[SWR_CK_PCK_EN]);
   endproperty
   a_sleep_pck: assert property (p_sleep_pck) else $error("peripheral clock wrong");

   property p_run_clocks;
      @(posedge aclk) disable iff (!aresetn)
      (st_q == SWR_RUN) |-> (cpu_clk_en && osc_en && prescaler_run && periph_clk_en);
   endproperty
   a_run_clocks: assert property (p_run_clocks) else $error("clock off in run");

   property p_stab_hold;
      @(posedge aclk) disable iff (!aresetn)
      (st_q == SWR_STAB && !low_voltage && cnt_q + 25'd1 < stab_cycles) |=>
         (st_q == SWR_STAB);
   endproperty
   a_stab_hold: assert property (p_stab_hold) else $error("stabilization cut short");

   property p_por_hold;
      @(posedge aclk) disable iff (!aresetn)
      sys_reset |-> (!cpu_clk_en && timer_run && osc_en);
   endproperty
   a_por_hold: assert property (p_por_hold) else $error("power-on hold clocks wrong");

   property p_mask_gate;
      @(posedge aclk) disable iff (!aresetn)
      (key_mask == 16'h0000) |-> !key_scan_wake;
   endproperty
   a_mask_gate: assert property (p_mask_gate) else $error("unmasked key woke");

endmodule : swr_top

// *** verif/swr_far.sv ***
// Far-side model: key switches, external lines, timer request and reset pin.
// Assumes the bench calls its tasks just after a rising edge of aclk.
`timescale 1ns/10ps
module swr_far
(
   input  wire logic aclk,
   output logic [7:0] key_port_a,
   output logic [7:0] key_port_b,
   output logic       ext_irq_one,
   output logic       ext_irq_two,
   output logic       interval_timer_flag,
   output logic       aresetn
);
   // Keys idle open on pulled-up pins; reset starts asserted.
   initial
   begin
      key_port_a = 8'hFF;
      key_port_b = 8'hFF;
      ext_irq_one = 1'b0;
      ext_irq_two = 1'b0;
      interval_timer_flag = 1'b0;
      aresetn = 1'b0;
   end
   // A short pulse would not be seen reliably, so two cycles is the floor.
   task automatic pin_reset(input int n);
      aresetn <= 1'b0;
      repeat ((n < 2) ? 2 : n) @(posedge aclk);
      aresetn <= 1'b1;
   endtask : pin_reset
   // One rising edge on the chosen external line, then back low.
   task automatic pulse(input logic two);
      if (two)
         ext_irq_two <= 1'b1;
      else
         ext_irq_one <= 1'b1;
      repeat (2) @(posedge aclk);
      ext_irq_one <= 1'b0;
      ext_irq_two <= 1'b0;
   endtask : pulse
   // Both external lines as plain levels, for background activity.
   task automatic lines(input logic one, input logic two);
      ext_irq_one <= one;
      ext_irq_two <= two;
   endtask : lines
   // Key levels as pressed by the user.
   task automatic keys(input logic [7:0] a, input logic [7:0] b);
      key_port_a <= a;
      key_port_b <= b;
   endtask : keys
   // Interval timer request level.
   task automatic tmr(input logic v);
      interval_timer_flag <= v;
   endtask : tmr
endmodule : swr_far

// *** verif/tb.sv ***
// Self-checking bench for the standby, wake and reset controller.
// Assumes the far-side model owns the pins; the bench is the bus master.
`timescale 1ns/10ps
module tb;
   import swr_pkg::*;
   localparam int POR_N = 16;
   logic aclk = 1'b0;
   logic aresetn, ext_irq_one, ext_irq_two, interval_timer_flag, low_voltage;
   logic [7:0] key_port_a, key_port_b, s_axi_awaddr, s_axi_araddr;
   logic [3:0] irq_pending, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, m, k, rd, x;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic cpu_clk_en, osc_en, periph_clk_en, prescaler_run, timer_run, sys_reset;
   logic key_scan_wake, wake_vector, ports_input_only;
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;
   int n, t0;

   swr_top #(.POR_CYCLES(POR_N)) swr_top_i (.aclk, .aresetn, .key_port_a, .key_port_b,
      .ext_irq_one, .ext_irq_two, .interval_timer_flag, .irq_pending, .low_voltage,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .cpu_clk_en, .osc_en, .periph_clk_en,
      .prescaler_run, .timer_run, .sys_reset, .key_scan_wake, .wake_vector,
      .ports_input_only);
   swr_far swr_far_i (.aclk, .key_port_a, .key_port_b, .ext_irq_one, .ext_irq_two,
      .interval_timer_flag, .aresetn);

   // ----------------------------------------
   // Clock, timeout and helpers
   // ----------------------------------------
   // A 4 ns clock; the ceiling is far above the expected run of about 800 cycles.
   always #2 aclk = ~aclk;
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         test_done();
      end
   end
   function automatic logic [31:0] rnd();
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction : rnd
   // Level bit i serves pins i and i+8; zero selects a low level.
   function automatic logic kexp(input logic [15:0] mk, input logic [15:0] kp,
                                 input logic [7:0] lv, input logic en);
      logic r;
      r = 1'b0;
      for (int i = 0; i < 16; i++)
         if (mk[i] && kp[i] == lv[i % 8]) r = 1'b1;
      return r && en;
   endfunction : kexp
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         $display("BAD time=%0t got=%h exp=%h", $time, got, exp);
         error_cnt++;
      end
   endtask : chk
   task automatic test_done();
      if (error_cnt == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done
   // Each half is released when taken; the trailing edge keeps bready single-driven.
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic aw_o, w_o;
      logic [31:0] r;
      aw_o = 1'b1;
      r = rnd();
      s_axi_wstrb <= r[3:0];
      w_o = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (aw_o || w_o)
      begin
         @(posedge aclk);
         if (aw_o && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (w_o && s_axi_wready) s_axi_wvalid <= 1'b0;
         aw_o = aw_o && !s_axi_awready;
         w_o = w_o && !s_axi_wready;
      end
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask : axw
   task automatic axr(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : axr
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      axr(a);
      chk(rd, e);
   endtask : rchk
   // Polls the state code; polling is bounded, the compare settles it.
   task automatic waitst(input logic [4:0] st);
      axr(SWR_OFF_STATUS);
      for (int i = 0; i < 200 && rd[4:0] !== st; i++) axr(SWR_OFF_STATUS);
      chk(rd[4:0], st);
   endtask : waitst

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   // Reset, register defaults, key wake, sleep, stop, refusal and lockout.
   initial
   begin
      x = 32'd76;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      irq_pending = 4'h0;
      low_voltage = 1'b0;
      swr_far_i.pin_reset(3);
      for (n = 0; sys_reset === 1'b1 && n < 100; n++)
      begin
         @(posedge aclk);
         if (n == 2) chk({cpu_clk_en, timer_run}, 2'b01);
      end
      chk(n >= POR_N && n <= POR_N + 2, 1'b1);
      rchk(SWR_OFF_MASK_LO, 32'h0);
      rchk(SWR_OFF_MASK_HI, 32'h0);
      rchk(SWR_OFF_LEVEL, 32'h0);
      rchk(SWR_OFF_CLK_CTRL, 32'h3);
      rchk(SWR_OFF_IRQ_EN, 32'h0);
      k = rnd();
      axr({k[7:2] | 6'h08, 2'b00});
      chk(rsp, SWR_RESP_SLVERR);
      axw({k[7:2] | 6'h08, 2'b00}, k);
      chk(rsp, SWR_RESP_SLVERR);
      waitst(5'h02);
      chk({cpu_clk_en, sys_reset}, 2'b10);
      // Sparse single-pin masks first, then dense random ones.
      for (int i = 0; i < 14; i++)
      begin
         m = rnd();
         k = rnd();
         if (i < 6) m[24:0] = {1'b1, m[23:16], 16'h1 << m[3:0]};
         axw(SWR_OFF_MASK_LO, {24'h0, m[7:0]});
         axw(SWR_OFF_MASK_HI, {24'h0, m[15:8]});
         axw(SWR_OFF_LEVEL, {24'h0, m[23:16]});
         axw(SWR_OFF_IRQ_EN, {31'h0, m[24]});
         swr_far_i.keys(k[7:0], k[15:8]);
         swr_far_i.lines(k[17], k[18]);
         swr_far_i.tmr(k[16]);
         irq_pending <= k[23:20];
         repeat (2) @(posedge aclk);
         chk(key_scan_wake, kexp(m[15:0], k[15:0], m[23:16], m[24]));
         rchk(SWR_OFF_MASK_HI, {24'h0, m[15:8]});
         rchk(SWR_OFF_LEVEL, 32'h0);
      end
      swr_far_i.lines(1'b0, 1'b0);
      swr_far_i.tmr(1'b0);
      irq_pending <= 4'h0;
      // Sleep with peripherals gated; line two is disabled, line one vectors.
      axw(SWR_OFF_CLK_CTRL, 32'h02);
      axw(SWR_OFF_IRQ_EN, 32'h12);
      axw(SWR_OFF_SLEEP, 32'h1);
      waitst(5'h04);
      chk({cpu_clk_en, osc_en, prescaler_run}, 3'b011);
      chk({timer_run, periph_clk_en}, 2'b10);
      swr_far_i.pulse(1'b1);
      waitst(5'h04);
      swr_far_i.pulse(1'b0);
      waitst(5'h02);
      chk({rd[6], wake_vector}, 2'b11);
      // Timer wake from sleep, global mask clear, so no vectoring.
      axw(SWR_OFF_IRQ_EN, 32'h08);
      axw(SWR_OFF_SLEEP, 32'h0);
      waitst(5'h04);
      swr_far_i.tmr(1'b1);
      waitst(5'h02);
      chk(wake_vector, 1'b0);
      swr_far_i.tmr(1'b0);
      // A pending enabled request blocks entry.
      irq_pending <= {1'b1, k[26:24]};
      axw(SWR_OFF_SLEEP, 32'h0);
      rchk(SWR_OFF_STATUS, {24'h0, 2'b00, kexp(m[15:0], k[15:0], m[23:16], 1'b1), 5'h02});
      irq_pending <= 4'h0;
      // Key wake from sleep: pin 0 of port a pressed to its low level.
      axw(SWR_OFF_MASK_LO, 32'h01);
      axw(SWR_OFF_LEVEL, 32'h00);
      axw(SWR_OFF_IRQ_EN, 32'h01);
      swr_far_i.keys(8'hFF, 8'hFF);
      axw(SWR_OFF_SLEEP, 32'h0);
      waitst(5'h04);
      swr_far_i.keys(8'hFE, 8'hFF);
      waitst(5'h02);
      chk(wake_vector, 1'b0);
      swr_far_i.keys(8'hFF, 8'hFF);
      // Stop ignores the timer, keeps registers, waits 256 cycles on wake.
      axw(SWR_OFF_IRQ_EN, 32'h0A);
      axw(SWR_OFF_STOP, 32'h0);
      waitst(5'h08);
      chk({osc_en, prescaler_run, timer_run, cpu_clk_en}, 4'h0);
      swr_far_i.tmr(1'b1);
      repeat (20) @(posedge aclk);
      axr(SWR_OFF_STATUS);
      chk(rd[4:0], 5'h08);
      swr_far_i.tmr(1'b0);
      rchk(SWR_OFF_MASK_HI, {24'h0, m[15:8]});
      swr_far_i.pulse(1'b0);
      waitst(5'h10);
      t0 = cyc;
      chk(cpu_clk_en, 1'b0);
      waitst(5'h02);
      chk(cyc - t0 > 240 && cyc - t0 < 272, 1'b1);
      rchk(SWR_OFF_CLK_CTRL, 32'h03);
      chk(periph_clk_en, 1'b1);
      // Lockout: an enabled edge cannot release it, only the reset pin.
      low_voltage <= 1'b1;
      @(posedge aclk);
      low_voltage <= 1'b0;
      waitst(5'h08);
      chk({rd[7], ports_input_only}, 2'b11);
      swr_far_i.pulse(1'b0);
      repeat (10) @(posedge aclk);
      axr(SWR_OFF_STATUS);
      chk(rd[4:0], 5'h08);
      swr_far_i.pin_reset(2);
      @(posedge aclk);
      chk({ports_input_only, sys_reset}, 2'b01);
      rchk(SWR_OFF_MASK_HI, 32'h0);
      test_done();
   end
endmodule : tb
